// *** hpa_seq_regs.vh ***
// Phase codes, count widths and limits for the host-port access sequencer
`ifndef HPA_SEQ_REGS_VH
`define HPA_SEQ_REGS_VH
`define PH_IDLE 6'h01
`define PH_ADDR 6'h02
`define PH_SETUP 6'h04
`define PH_STROBE 6'h08
`define PH_HOLD 6'h10
`define PH_RECOV 6'h20
`define PH_CNT_W 4
`define ADDR_CNT_MIN 4'h2
`define SETUP_CNT_MIN 4'h2
`define STROBE_CNT_MIN 4'h1
`define ADDR_RST 24'h000000
`define DATA_RST 16'h0000
`define CS_RST 8'h00
`endif

// *** host_port_access_sequencer.v ***
// Host-port access sequencer for the sixteen-bit host-port expansion bus
// Summary of operation
// - Address driven with chip select; valid 4 to 64 clocks.
// - First data strobe starts 2 to 32 clocks after chip select.
// - First data strobe pulse lasts 1 to 16 clocks.
// - Write data valid 3 to 48 clocks before strobe rising edge.
// - Write data held 1 to 16 clocks after strobe rising edge.
// - Read data sampled 1 to 16 clocks after strobe falling edge.
// - Recovery gap of 2 to 17 clocks set by recovery count.
// - Host ready held keeps address or strobe phase going.
// - One shared active-low wait input for chip selects 0 to 7.
// - Wait in read strobe holds it while low and drops its count, then goes straight to hold.
// - Wait ignored outside the strobe phase of reads.
// - Chip selects 4 to 7 use ready lines 0 to 3.
// - Each ready input has software-selected polarity.
// - All phase counts are in expansion bus clocks.
`timescale 1ns/10ps
`include "hpa_seq_regs.vh"
module host_port_access_sequencer #(
  parameter AW = 24,
  parameter DW = 16
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Phase configuration
  input wire [`PH_CNT_W-1:0] i_address_phase_count,
  input wire [`PH_CNT_W-1:0] i_setup_phase_count,
  input wire [`PH_CNT_W-1:0] i_strobe_phase_count,
  input wire [`PH_CNT_W-1:0] i_hold_phase_count,
  input wire [`PH_CNT_W-1:0] i_recovery_phase_count,
  input wire [7:0] i_sixteen_bit_host_port_mode,
  input wire [3:0] i_ready_active_high,
  // Request side
  input wire i_req_valid,
  output wire o_req_ready,
  input wire i_req_write,
  input wire [2:0] i_req_cs,
  input wire [AW-1:0] i_req_addr,
  input wire [DW-1:0] i_req_wdata,
  output reg o_rd_valid_ff,
  output reg [DW-1:0] o_rd_data_ff,
  output wire o_busy,
  output wire o_cfg_error,
  // Expansion bus pins
  output reg [7:0] o_cs_low_ff,
  output reg [AW-1:0] o_addr_ff,
  output reg o_host_data_strobe_one_low_ff,
  output reg o_write_low_ff,
  output reg [DW-1:0] o_data_out_ff,
  output reg o_data_oe_ff,
  input wire [DW-1:0] i_data_in,
  input wire i_shared_wait_low,
  input wire [3:0] i_per_select_ready
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

reg [DW-1:0] data_s1_ff, data_s2_ff;
reg wait_s1_ff, wait_s2_ff;
reg [3:0] rdy_s1_ff, rdy_s2_ff;

always @(posedge i_clk) begin
  if (i_rst) begin
    data_s1_ff <= `DATA_RST;
    data_s2_ff <= `DATA_RST;
    wait_s1_ff <= 1'b1;
    wait_s2_ff <= 1'b1;
    rdy_s1_ff <= 4'h0;
    rdy_s2_ff <= 4'h0;
  end else begin
    data_s1_ff <= i_data_in;
    data_s2_ff <= data_s1_ff;
    wait_s1_ff <= i_shared_wait_low;
    wait_s2_ff <= wait_s1_ff;
    rdy_s1_ff <= i_per_select_ready;
    rdy_s2_ff <= rdy_s1_ff;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer

localparam [5:0] S_IDLE = `PH_IDLE;
localparam [5:0] S_ADDR = `PH_ADDR;
localparam [5:0] S_SETUP = `PH_SETUP;
localparam [5:0] S_STROBE = `PH_STROBE;
localparam [5:0] S_HOLD = `PH_HOLD;
localparam [5:0] S_RECOV = `PH_RECOV;

reg [5:0] state_ff, nxt_state;
reg [`PH_CNT_W-1:0] cnt_ff, nxt_cnt;
reg write_ff;
reg [2:0] cs_ff;
wire [3:0] rdy_norm;
wire host_ready;
wire wait_on;

// Active-level ready, true while the peripheral is busy
assign rdy_norm = rdy_s2_ff ^ ~i_ready_active_high;
// Only selects 4..7 in host-port mode see a ready line
assign host_ready = cs_ff[2] & i_sixteen_bit_host_port_mode[cs_ff] &
                    rdy_norm[cs_ff[1:0]];
// Shared wait honoured only in a read strobe phase, any select 0..7
assign wait_on = ~wait_s2_ff & ~write_ff &
                 (state_ff == S_STROBE);

assign o_req_ready = (state_ff == S_IDLE);
assign o_busy = (state_ff != S_IDLE);
// Flags settings too short to catch a ready change
assign o_cfg_error = (i_address_phase_count < `ADDR_CNT_MIN) |
                     (i_setup_phase_count < `SETUP_CNT_MIN) |
                     (i_strobe_phase_count < `STROBE_CNT_MIN);

// Count each phase down from its programmed value; phase = count + 1
always @* begin
  nxt_state = state_ff;
  nxt_cnt = cnt_ff;
  case (state_ff)
    S_IDLE: begin
      if (i_req_valid) begin
        nxt_state = S_ADDR;
        nxt_cnt = i_address_phase_count;
      end
    end
    S_ADDR: begin
      if (cnt_ff != 0) begin
        nxt_cnt = cnt_ff - 1'b1;
      end else if (!host_ready) begin
        nxt_state = S_SETUP;
        nxt_cnt = i_setup_phase_count;
      end
    end
    S_SETUP: begin
      if (cnt_ff != 0) begin
        nxt_cnt = cnt_ff - 1'b1;
      end else begin
        nxt_state = S_STROBE;
        nxt_cnt = i_strobe_phase_count;
      end
    end
    S_STROBE: begin
      if (wait_on) begin
        nxt_cnt = {`PH_CNT_W{1'b0}};
      end else if (cnt_ff != 0 && !(~write_ff && ~wait_s2_ff)) begin
        nxt_cnt = cnt_ff - 1'b1;
      end else if (!host_ready) begin
        nxt_state = S_HOLD;
        nxt_cnt = i_hold_phase_count;
      end
    end
    S_HOLD: begin
      if (cnt_ff != 0) begin
        nxt_cnt = cnt_ff - 1'b1;
      end else begin
        nxt_state = S_RECOV;
        nxt_cnt = i_recovery_phase_count;
      end
    end
    S_RECOV: begin
      if (cnt_ff != 0) begin
        nxt_cnt = cnt_ff - 1'b1;
      end else begin
        nxt_state = S_IDLE;
      end
    end
    default: begin
      nxt_state = S_IDLE;
      nxt_cnt = {`PH_CNT_W{1'b0}};
    end
  endcase
end

// One-hot decode of the selected chip select
function [7:0] cs_dec;
  input [2:0] sel;
  begin
    cs_dec = 8'h01 << sel;
  end
endfunction

always @(posedge i_clk) begin
  if (i_rst) begin
    state_ff <= S_IDLE;
    cnt_ff <= {`PH_CNT_W{1'b0}};
    write_ff <= 1'b0;
    cs_ff <= 3'h0;
    o_cs_low_ff <= 8'hff;
    o_addr_ff <= `ADDR_RST;
    o_host_data_strobe_one_low_ff <= 1'b1;
    o_write_low_ff <= 1'b1;
    o_data_out_ff <= `DATA_RST;
    o_data_oe_ff <= 1'b0;
    o_rd_valid_ff <= 1'b0;
    o_rd_data_ff <= `DATA_RST;
  end else begin
    state_ff <= nxt_state;
    cnt_ff <= nxt_cnt;
    o_rd_valid_ff <= 1'b0;
    if (state_ff == S_IDLE && i_req_valid) begin
      write_ff <= i_req_write;
      cs_ff <= i_req_cs;
      // Address, select and write data all appear together
      o_cs_low_ff <= ~cs_dec(i_req_cs);
      o_addr_ff <= i_req_addr;
      o_write_low_ff <= ~i_req_write;
      o_data_out_ff <= i_req_wdata;
      o_data_oe_ff <= i_req_write;
    end
    if (nxt_state == S_STROBE) begin
      o_host_data_strobe_one_low_ff <= 1'b0;
    end else begin
      o_host_data_strobe_one_low_ff <= 1'b1;
    end
    // Read data captured as the strobe ends, per the strobe length
    if (state_ff == S_STROBE && nxt_state == S_HOLD && !write_ff) begin
      o_rd_valid_ff <= 1'b1;
      o_rd_data_ff <= data_s2_ff;
    end
    // Select, address and data stay through hold; select, write and data enable released in recovery, address kept
    if (state_ff == S_HOLD && nxt_state == S_RECOV) begin
      o_cs_low_ff <= 8'hff;
      o_write_low_ff <= 1'b1;
      o_data_oe_ff <= 1'b0;
    end
  end
end

endmodule

// *** hpa_seq_sva.sv ***
// Pin-level assertions for the access sequencer
`timescale 1ns/10ps
module hpa_seq_sva (
  input wire i_clk,
  input wire i_rst,
  input wire o_req_ready,
  input wire o_rd_valid_ff,
  input wire [7:0] o_cs_low_ff,
  input wire [23:0] o_addr_ff,
  input wire o_host_data_strobe_one_low_ff,
  input wire o_write_low_ff,
  input wire [15:0] o_data_out_ff
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire cs = ~&o_cs_low_ff;
  wire sn = o_host_data_strobe_one_low_ff;
  sequence s_pulse;
    !sn [*2];
  endsequence
  sequence s_gap;
    !o_req_ready ##1 !cs;
  endsequence
  chk_addr_held: assert property (
    cs && $past(cs) |-> $stable(o_addr_ff)) else $error("addr moved");
  chk_wdata_held: assert property (
    cs && $past(cs) && !o_write_low_ff |-> $stable(o_data_out_ff))
    else $error("wdata moved");
  chk_cs_onehot: assert property (
    $onehot0(~o_cs_low_ff)) else $error("two selects");
  chk_strobe_lead: assert property (
    !sn |-> cs && $past(cs, 5)) else $error("strobe too early");
  chk_pulse_min: assert property (
    $fell(sn) |-> s_pulse) else $error("strobe too short");
  chk_rdv_at_end: assert property (
    $rose(sn) |-> cs && o_rd_valid_ff == o_write_low_ff)
    else $error("bad strobe end");
  chk_rdv_once: assert property (
    o_rd_valid_ff |=> !o_rd_valid_ff) else $error("rdv too long");
  chk_recov_gap: assert property (
    $fell(cs) |-> s_gap) else $error("no recovery");
endmodule
bind host_port_access_sequencer hpa_seq_sva chk (.i_clk, .i_rst,
  .o_req_ready, .o_rd_valid_ff, .o_cs_low_ff, .o_addr_ff,
  .o_host_data_strobe_one_low_ff, .o_write_low_ff, .o_data_out_ff);

// *** hpa_peer.sv ***
// Slow peripheral model: read data and wait stretching
`timescale 1ns/10ps
module hpa_peer (
  input wire i_clk,
  input wire i_strobe_low,
  input wire [23:0] i_addr,
  input wire [3:0] i_stall,
  output wire [15:0] o_data,
  output wire o_wait_low
);
  reg [3:0] n_ff = 4'h0;
  reg t_ff = 1'b0;
  always @(posedge i_clk) begin
    t_ff <= ~t_ff;
    n_ff <= i_strobe_low ? 4'h0 : n_ff + 4'h1;
  end
  // Churns when released so stale data never passes
  assign o_data = i_addr[15:0] ^ (i_strobe_low ? {16{t_ff}} : 16'h5a5a);
  // Waits on writes too, which must be ignored
  assign o_wait_low = i_strobe_low | (n_ff >= i_stall);
endmodule

// *** tb_top.sv ***
// Randomised self-checking bench for the access sequencer
`timescale 1ns/10ps
module tb_top;
  reg i_clk = 0, i_rst = 1, i_req_valid = 0, i_req_write = 0;
  reg [3:0] ac = 2, sc = 2, tc = 1, hc = 0, rc = 0, stall = 0, pol = 0, rdy = 0;
  reg [7:0] mode = 0;
  reg [2:0] i_req_cs = 0;
  reg [23:0] i_req_addr = 0;
  reg [15:0] i_req_wdata = 0;
  wire [7:0] cs_n;
  wire [23:0] addr;
  wire [15:0] dout, din, rdd;
  wire busy, ready, rdv, sn, wn, oe, cerr, wait_n;
  int fails = 0, check_count = 0, cyc = 0;
  host_port_access_sequencer uut (.i_clk, .i_rst,
    .i_address_phase_count(ac), .i_setup_phase_count(sc),
    .i_strobe_phase_count(tc), .i_hold_phase_count(hc),
    .i_recovery_phase_count(rc), .i_sixteen_bit_host_port_mode(mode),
    .i_ready_active_high(pol), .i_req_valid, .o_req_ready(ready),
    .i_req_write, .i_req_cs, .i_req_addr, .i_req_wdata, .o_rd_valid_ff(rdv),
    .o_rd_data_ff(rdd), .o_busy(busy), .o_cfg_error(cerr), .o_cs_low_ff(cs_n),
    .o_addr_ff(addr), .o_host_data_strobe_one_low_ff(sn), .o_write_low_ff(wn),
    .o_data_out_ff(dout), .o_data_oe_ff(oe), .i_data_in(din),
    .i_shared_wait_low(wait_n), .i_per_select_ready(rdy));
  hpa_peer peer (.i_clk, .i_strobe_low(sn), .i_addr(addr), .i_stall(stall),
    .o_data(din), .o_wait_low(wait_n));
  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 9000) begin
      fails++;
      test_done;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function [15:0] rd_exp(input [23:0] a);
    rd_exp = a[15:0] ^ 16'h5a5a;
  endfunction
  task cmp(input string nm, input logic [31:0] e, g);
    check_count++;
    if (e !== g) begin
      fails++;
      $display("ERROR %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task acc(input bit we, input bit hr);
    int n, f, p, b, v, m;
    bit ok, pl;
    begin
      n = 0; f = 0; p = 0; b = 0; v = 0; ok = 1;
      m = ac + sc + tc + hc + rc + 5;
      cmp("idle", 1, ready && !cerr);
      i_req_write = we;
      i_req_cs = $urandom;
      i_req_addr = $urandom;
      i_req_wdata = $urandom;
      // Only the line of this select is held
      rdy = ~pol ^ ({3'h0, hr} << i_req_cs[1:0]);
      pl = !(hr && i_req_cs[2] && mode[i_req_cs]);
      i_req_valid = 1;
      @(posedge i_clk) #1 i_req_valid = 0;
      b = busy;
      do begin
        @(posedge i_clk) #1 n++;
        if (n == 6 || n == f + 8) rdy = ~pol;
        b += busy;
        p += !sn;
        v += rdv;
        if (!sn && f == 0) f = n;
        // Raise ready again as the strobe starts
        if (!pl && n == f) rdy = ~pol ^ (4'h1 << i_req_cs[1:0]);
        if (rdv) cmp("rdata", rd_exp(i_req_addr), rdd);
        if (~&cs_n) ok &= addr === i_req_addr && cs_n === ~(8'h01 << i_req_cs)
          && oe === we && wn === !we && (!we || dout === i_req_wdata);
      end while (busy && n < 300);
      cmp("reads", !we, v);
      cmp("pins", 1, ok);
      if (pl) cmp("lead", ac + sc + 2, f);
      if (!pl) cmp("strobe_held", 1, p > tc + 1);
      else if (we || stall == 0) cmp("pulse", tc + 1, p);
      else cmp("stretch", 1, p >= stall && p <= stall + tc + 4);
      if (!pl) cmp("held", 1, b > m);
      else if (we || stall == 0) cmp("busy", m, b);
    end
  endtask
  task test_done;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    void'($urandom(92895));
    repeat (16) @(posedge i_clk);
    #1 i_rst = 0;
    for (int i = 0; i < 80; i++) begin
      ac = 2 + $urandom % 3;
      sc = 2 + $urandom % 3;
      tc = 3 + $urandom % 4;
      hc = $urandom % 4;
      rc = $urandom % 4;
      stall = $urandom % 7;
      mode = $urandom;
      pol = $urandom;
      // Shortest write, then longest read
      if (i < 2) {ac, sc, tc, hc, rc} = i ? 20'hfffff : 20'h22100;
      acc(i == 0 || (i > 1 && $urandom % 2), i > 1 && $urandom % 2);
    end
    ac = 1;
    #1 cmp("cfg", 1, cerr);
    test_done;
  end
endmodule
